/* rtl/jisp_pkg.sv */
package jisp_pkg;

   // ************************************************
   // Instruction codes
   // ************************************************
   localparam int IR_W = 4;
   localparam logic [3:0] IR_IDCODE = 4'h1;
   localparam logic [3:0] IR_ENABLE = 4'h9;
   localparam logic [3:0] IR_ERASE = 4'hA;
   localparam logic [3:0] IR_PROGRAM = 4'hB;
   localparam logic [3:0] IR_VERIFY = 4'hC;
   localparam logic [3:0] IR_BYPASS = 4'hF;
   localparam logic [3:0] IR_CAPTURE = 4'h1;
   localparam logic [3:0] IR_RESET = 4'h1;

   // ************************************************
   // Data registers and array
   // ************************************************
   localparam int ID_W = 32;
   localparam int ADDR_W = 6;
   localparam int ROW_W = 32;
   localparam int PSR_W = ADDR_W + ROW_W;
   localparam int ROWS = 64;
   localparam logic [ROW_W-1:0] ERASED_ROW = 32'hFFFFFFFF;
   localparam logic [PSR_W-1:0] PSR_RESET = 38'h00_0000_0000;
   // Arbitrary identification value
   localparam logic [ID_W-1:0] ID_VALUE = 32'h0A5C_3001;

   // ************************************************
   // Timing
   // ************************************************
   localparam int CLK_KHZ = 200000;
   localparam int ERASE_PULSE_WIDTH_MS = 100;
   localparam int PROGRAM_PULSE_WIDTH_MS = 10;
   localparam int VERIFY_PULSE_WIDTH_US = 10;
   localparam int ERASE_CYCLES = ERASE_PULSE_WIDTH_MS * CLK_KHZ;
   localparam int PROGRAM_CYCLES = PROGRAM_PULSE_WIDTH_MS * CLK_KHZ;
   localparam int VERIFY_CYCLES = (VERIFY_PULSE_WIDTH_US * CLK_KHZ + 999) / 1000;

   // ************************************************
   // Types
   // ************************************************
   typedef enum logic [3:0] {
      TAP_TLR = 4'h0, TAP_RTI = 4'h1, TAP_SELDR = 4'h3, TAP_CAPDR = 4'h2,
      TAP_SHDR = 4'h6, TAP_EX1DR = 4'h7, TAP_PADR = 4'h5, TAP_EX2DR = 4'h4,
      TAP_UPDR = 4'hC, TAP_SELIR = 4'hD, TAP_CAPIR = 4'hF, TAP_SHIR = 4'hE,
      TAP_EX1IR = 4'hA, TAP_PAIR = 4'hB, TAP_EX2IR = 4'h9, TAP_UPIR = 4'h8
   } jisp_tap_e_t;

   typedef enum logic [1:0] {
      OP_ERASE = 2'h0, OP_PROGRAM = 2'h1, OP_VERIFY = 2'h2
   } jisp_op_e_t;

   typedef struct packed {
      jisp_op_e_t op;
      logic [ADDR_W-1:0] addr;
      logic [ROW_W-1:0] data;
   } jisp_cmd_t;

   typedef enum logic [1:0] {
      SEL_BYPASS = 2'h0, SEL_ID = 2'h1, SEL_PSR = 2'h2
   } jisp_sel_e_t;

endpackage

/* rtl/jisp_row_mem.sv */
`timescale 1ns/1ps
module jisp_row_mem
   import jisp_pkg::*;
#(
   parameter int DEPTH = ROWS,
   parameter int WIDTH = ROW_W
) (
   // Clock
   input wire logic clk,
   // Write port
   input wire logic we,
   input wire logic [$clog2(DEPTH)-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   // Read port
   input wire logic re,
   input wire logic [$clog2(DEPTH)-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];

   initial begin
      if (DEPTH < 2 || WIDTH < 1) begin
         $error("jisp_row_mem: bad geometry");
      end
   end

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // Registered read data, one cycle after re
   always_ff @(posedge clk) begin
      if (re) begin
         rdata <= mem[raddr];
      end
   end
endmodule // jisp_row_mem

/* rtl/jisp_tap.sv */
// Operation
// R1 - Code 1111 puts one-bit bypass in path
// R2 - Bypass passes scan without disturbing logic
// R3 - Master may load bypass with TDI high
// R4 - Code 0001 shifts identification value out
// R5 - Code 1001 arms erase, program, verify
// R6 - Master arms before first programming command
// R7 - Code 1010 erases the whole array
// R8 - Code 1011 writes shift register to row
// R9 - Code 1100 loads addressed row into register
// R10 - TDI sampled rising, TDO changes falling, tristated
// R11 - Master holds TMS high in user mode
// R12 - Power-up reset resets the test controller
// R13 - Sixteen-state controller, 4-bit IR, unknown codes bypass
// R14 - Master waits pulse width after each operation
`timescale 1ns/1ps
module jisp_tap
   import jisp_pkg::*;
#(
   parameter int ERASE_PW = ERASE_CYCLES,
   parameter int PROGRAM_PW = PROGRAM_CYCLES,
   parameter int VERIFY_PW = VERIFY_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Test pins
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdoOe,
   // Status
   output logic ispArmed,
   output logic nvBusy,
   output logic cmdStall
);
   initial begin
      if (ERASE_PW < ROWS || PROGRAM_PW < 1 || VERIFY_PW < 2) begin
         $error("jisp_tap: pulse widths too short");
      end
   end

   // ************************************************
   // Pin synchronisers and edge detect
   // ************************************************
   logic tckS1, tckS2, tckPrev, tmsS1, tmsS2, tdiS1, tdiS2;
   logic tckRise, tckFall;

   always_ff @(posedge clk) begin
      tckS1 <= tck;
      tckS2 <= tckS1;
      tckPrev <= tckS2;
      tmsS1 <= tms;
      tmsS2 <= tmsS1;
      tdiS1 <= tdi;
      tdiS2 <= tdiS1;
   end

   assign tckRise = tckS2 && !tckPrev;
   assign tckFall = !tckS2 && tckPrev;

   function automatic jisp_tap_e_t tapNext(input jisp_tap_e_t s, input logic m);
      case (s)
         TAP_TLR: tapNext = m ? TAP_TLR : TAP_RTI;
         TAP_RTI: tapNext = m ? TAP_SELDR : TAP_RTI;
         TAP_SELDR: tapNext = m ? TAP_SELIR : TAP_CAPDR;
         TAP_CAPDR: tapNext = m ? TAP_EX1DR : TAP_SHDR;
         TAP_SHDR: tapNext = m ? TAP_EX1DR : TAP_SHDR;
         TAP_EX1DR: tapNext = m ? TAP_UPDR : TAP_PADR;
         TAP_PADR: tapNext = m ? TAP_EX2DR : TAP_PADR;
         TAP_EX2DR: tapNext = m ? TAP_UPDR : TAP_SHDR;
         TAP_UPDR: tapNext = m ? TAP_SELDR : TAP_RTI;
         TAP_SELIR: tapNext = m ? TAP_TLR : TAP_CAPIR;
         TAP_CAPIR: tapNext = m ? TAP_EX1IR : TAP_SHIR;
         TAP_SHIR: tapNext = m ? TAP_EX1IR : TAP_SHIR;
         TAP_EX1IR: tapNext = m ? TAP_UPIR : TAP_PAIR;
         TAP_PAIR: tapNext = m ? TAP_EX2IR : TAP_PAIR;
         TAP_EX2IR: tapNext = m ? TAP_UPIR : TAP_SHIR;
         TAP_UPIR: tapNext = m ? TAP_SELDR : TAP_RTI;
         default: tapNext = TAP_TLR;
      endcase
   endfunction

   // R13 unknown codes bypass
   function automatic jisp_sel_e_t drSel(input logic [IR_W-1:0] code);
      case (code)
         IR_IDCODE: drSel = SEL_ID;
         IR_ENABLE, IR_ERASE, IR_PROGRAM, IR_VERIFY: drSel = SEL_PSR;
         default: drSel = SEL_BYPASS;
      endcase
   endfunction

   // ************************************************
   // Controller and instruction register
   // ************************************************
   jisp_tap_e_t tapState;
   logic [IR_W-1:0] ir, irShift;
   logic pendSet;
   jisp_cmd_t pendCmd;
   logic [PSR_W-1:0] psr;

   // R12 R13 power-up reset and state walk
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tapState <= TAP_TLR;
      end else if (tckRise) begin
         tapState <= tapNext(tapState, tmsS2);
      end
   end

   // R13 capture, shift, update
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irShift <= IR_CAPTURE;
         ir <= IR_RESET;
      end else if (tckRise) begin
         if (tapState == TAP_TLR) begin
            ir <= IR_RESET;
         end else if (tapState == TAP_CAPIR) begin
            irShift <= IR_CAPTURE;
         end else if (tapState == TAP_SHIR) begin
            irShift <= {tdiS2, irShift[IR_W-1:1]};
         end else if (tapState == TAP_UPIR) begin
            ir <= irShift;
         end
      end
   end

   // R5 arming lasts until test-logic-reset
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ispArmed <= 1'b0;
      end else if (tckRise && tapState == TAP_TLR) begin
         ispArmed <= 1'b0;
      end else if (tckRise && tapState == TAP_UPIR && irShift == IR_ENABLE) begin
         ispArmed <= 1'b1;
      end
   end

   // R5 operations launch only when armed
   assign pendSet = tckRise && tapState == TAP_UPIR && ispArmed &&
                    (irShift == IR_ERASE || irShift == IR_PROGRAM || irShift == IR_VERIFY);
   always_comb begin
      pendCmd.op = (irShift == IR_ERASE) ? OP_ERASE :
                   (irShift == IR_PROGRAM) ? OP_PROGRAM : OP_VERIFY;
      pendCmd.addr = psr[PSR_W-1:ROW_W];
      pendCmd.data = psr[ROW_W-1:0];
   end

   // ************************************************
   // Data registers
   // ************************************************
   logic bypassReg;
   logic [ID_W-1:0] idShift;
   logic verifyLoad;
   logic [ROW_W-1:0] memRdata;

   // R1 R2 single-bit bypass stage
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         bypassReg <= 1'b0;
      end else if (tckRise && drSel(ir) == SEL_BYPASS) begin
         if (tapState == TAP_CAPDR) begin
            bypassReg <= 1'b0;
         end else if (tapState == TAP_SHDR) begin
            bypassReg <= tdiS2;
         end
      end
   end

   // R4 identification capture and shift
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         idShift <= ID_VALUE;
      end else if (tckRise && drSel(ir) == SEL_ID) begin
         if (tapState == TAP_CAPDR) begin
            idShift <= ID_VALUE;
         end else if (tapState == TAP_SHDR) begin
            idShift <= {tdiS2, idShift[ID_W-1:1]};
         end
      end
   end

   // R9 verify result loads the data field
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         psr <= PSR_RESET;
      end else if (verifyLoad) begin
         psr[ROW_W-1:0] <= memRdata;
      end else if (tckRise && tapState == TAP_SHDR && drSel(ir) == SEL_PSR) begin
         psr <= {tdiS2, psr[PSR_W-1:1]};
      end
   end

   // R10 TDO moves on the falling edge, driven only while shifting
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tdo <= 1'b0;
         tdoOe <= 1'b0;
      end else if (tckFall) begin
         tdoOe <= (tapState == TAP_SHIR) || (tapState == TAP_SHDR);
         if (tapState == TAP_SHIR) begin
            tdo <= irShift[0];
         end else begin
            case (drSel(ir))
               SEL_ID: tdo <= idShift[0];
               SEL_PSR: tdo <= psr[0];
               default: tdo <= bypassReg;
            endcase
         end
      end
   end

   // ************************************************
   // Command hand-off and two-entry buffer
   // ************************************************
   logic pendValid, bufInReady, bufOutValid, pop;
   jisp_cmd_t pendHold, bufHead;
   jisp_cmd_t slot [2];
   logic rdPtr, wrPtr;
   logic [1:0] bufCount;

   // A command waits here while the two-entry buffer is full
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pendValid <= 1'b0;
      end else if (pendSet) begin
         pendValid <= 1'b1;
      end else if (bufInReady) begin
         pendValid <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (pendSet) begin
         pendHold <= pendCmd;
      end
   end

   assign bufInReady = bufCount != 2'h2;
   assign bufOutValid = bufCount != 2'h0;
   assign bufHead = slot[rdPtr];
   assign cmdStall = pendValid && !bufInReady;

   always_ff @(posedge clk) begin
      if (pendValid && bufInReady) begin
         slot[wrPtr] <= pendHold;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         bufCount <= 2'h0;
         rdPtr <= 1'b0;
         wrPtr <= 1'b0;
      end else begin
         if (pendValid && bufInReady) begin
            wrPtr <= !wrPtr;
         end
         if (pop) begin
            rdPtr <= !rdPtr;
         end
         bufCount <= bufCount + 2'((pendValid && bufInReady) ? 1 : 0) - 2'(pop ? 1 : 0);
      end
   end

   // ************************************************
   // Nonvolatile array sequencer
   // ************************************************
   logic [31:0] busyCnt;
   logic eraseRun;
   logic [ADDR_W-1:0] eraseIdx;
   logic memWe, memRe;
   logic [ADDR_W-1:0] memWaddr;
   logic [ROW_W-1:0] memWdata;

   assign pop = bufOutValid && busyCnt == 32'h0;
   assign nvBusy = busyCnt != 32'h0;
   assign memRe = pop && bufHead.op == OP_VERIFY;

   // R8 program write; R7 erase sweep writes every row
   always_comb begin
      memWe = eraseRun || (pop && bufHead.op == OP_PROGRAM);
      memWaddr = eraseRun ? eraseIdx : bufHead.addr;
      memWdata = eraseRun ? ERASED_ROW : bufHead.data;
   end

   // Pulse width hold-off keeps the buffer's drain side stalled
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         busyCnt <= 32'h0;
      end else if (pop) begin
         case (bufHead.op)
            OP_ERASE: busyCnt <= 32'(ERASE_PW);
            OP_PROGRAM: busyCnt <= 32'(PROGRAM_PW);
            default: busyCnt <= 32'(VERIFY_PW);
         endcase
      end else if (busyCnt != 32'h0) begin
         busyCnt <= busyCnt - 32'h1;
      end
   end

   // R7 erase walks all rows
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         eraseRun <= 1'b0;
         eraseIdx <= '0;
      end else if (pop && bufHead.op == OP_ERASE) begin
         eraseRun <= 1'b1;
         eraseIdx <= '0;
      end else if (eraseRun) begin
         eraseIdx <= eraseIdx + 1'b1;
         eraseRun <= eraseIdx != ADDR_W'(ROWS - 1);
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         verifyLoad <= 1'b0;
      end else begin
         verifyLoad <= memRe;
      end
   end

   jisp_row_mem #(.DEPTH(ROWS), .WIDTH(ROW_W)) uMem (
      .clk(clk),
      .we(memWe),
      .waddr(memWaddr),
      .wdata(memWdata),
      .re(memRe),
      .raddr(bufHead.addr),
      .rdata(memRdata)
   );

   // ************************************************
   // Assertions
   // ************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   AST_TLR_AFTER_RESET: assert property ($rose(reset_n) |-> tapState == TAP_TLR) // R12
      else $error("controller not in reset state after reset");
   AST_BYPASS_DELAY: assert property (tckRise && tapState == TAP_SHDR && ir == IR_BYPASS // R1
      |=> bypassReg == $past(tdiS2)) else $error("bypass bit did not take TDI");
   AST_BYPASS_QUIET: assert property (tckRise && tapState == TAP_SHDR && ir == IR_BYPASS // R2
      && !verifyLoad |=> $stable(psr) && $stable(ispArmed)) else $error("bypass disturbed state");
   AST_ID_CAPTURE: assert property (tckRise && tapState == TAP_CAPDR && ir == IR_IDCODE // R4
      |=> idShift == ID_VALUE) else $error("identification not captured");
   AST_ARMED_ONLY: assert property (pendSet |-> ispArmed) // R5
      else $error("operation launched while not armed");
   AST_ERASE_SWEEP: assert property (pop && bufHead.op == OP_ERASE // R7
      |=> eraseRun && eraseIdx == '0 ##1 eraseIdx == ADDR_W'(1)) else $error("erase sweep wrong");
   AST_PROGRAM_WRITE: assert property (pop && bufHead.op == OP_PROGRAM && !eraseRun // R8
      |-> memWe && memWaddr == bufHead.addr && memWdata == bufHead.data)
      else $error("program write missing");
   AST_VERIFY_LOAD: assert property (memRe |-> ##2 psr[ROW_W-1:0] == $past(memRdata)) // R9
      else $error("verify data not loaded");
   AST_TDO_FALL: assert property ($changed(tdo) |-> $past(tckFall)) // R10
      else $error("TDO changed off the falling edge");
   AST_TDO_Z: assert property (tckFall && tapState != TAP_SHDR && tapState != TAP_SHIR // R10
      |=> !tdoOe) else $error("TDO driven outside shift");
   AST_IR_UPDATE: assert property (tckRise && tapState == TAP_UPIR |=> ir == $past(irShift)) // R13
      else $error("instruction not updated");

   COV_BYPASS: cover property (tckRise && tapState == TAP_SHDR && ir == IR_BYPASS);
   COV_IDCODE: cover property (tckRise && tapState == TAP_SHDR && ir == IR_IDCODE);
   COV_ERASE: cover property (pop && bufHead.op == OP_ERASE);
   COV_STALL: cover property (cmdStall);
endmodule // jisp_tap

/* verif/jisp_jtag_master.sv */
`timescale 1ns/1ps
module jisp_jtag_master (
   // Clock
   input wire logic clk,
   // Test pins
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdoLine
);
   // ********
   // Pin driving
   // ********
   // clock still, tms high until the first frame
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end

   // change on low phase, sample at rise
   task automatic step(input logic tmsV, input logic tdiV, output logic tdoV);
      @(posedge clk);
      tms <= tmsV;
      tdi <= tdiV;
      repeat (7) @(posedge clk);
      tdoV = tdoLine;
      tck <= 1'b1;
      repeat (8) @(posedge clk);
      tck <= 1'b0;
   endtask

   // idle bits, tdi back at pull-up level
   task automatic goIdle(input int n);
      logic b;
      repeat (n) step(1'b0, 1'b1, b);
   endtask

   // five high tms bits reach reset state
   task automatic resetTap();
      logic b;
      repeat (5) step(1'b1, 1'b1, b);
   endtask

   // one scan from idle back to idle
   task automatic scan(input logic isIr, input int width, input logic [63:0] din,
                       output logic [63:0] dout);
      logic b;
      dout = '0;
      step(1'b1, 1'b1, b);
      if (isIr) step(1'b1, 1'b1, b);
      step(1'b0, 1'b1, b);
      step(1'b0, 1'b1, b);
      for (int i = 0; i < width; i++) begin
         step(i == width - 1, din[i], b);
         dout[i] = b;
      end
      step(1'b1, 1'b1, b);
      step(1'b0, 1'b1, b);
   endtask
endmodule // jisp_jtag_master

/* verif/tb_jtag_isp_command_port.sv */
`timescale 1ns/1ps
module tb_jtag_isp_command_port;
   import jisp_pkg::*;
   localparam int ERASE_T = 64;
   localparam int PROG_T = 4;
   localparam int TIMEOUT = 40000;
   logic clk;
   logic reset_n;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic tdoOe;
   logic ispArmed;
   logic nvBusy;
   logic cmdStall;
   logic tdoLine;
   logic tdoPrev;
   logic [63:0] rd;
   int errors = 0;
   int n_tests = 0;
   int cycles = 0;
   int busyCnt = 0;

   // Pull-up holds the released line high
   assign tdoLine = tdoOe ? tdo : 1'b1;

   // Verify runs at its full default width, so that value is exercised too
   jisp_tap #(.ERASE_PW(ERASE_T), .PROGRAM_PW(PROG_T)) u_dut (
      .clk(clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
      .tdoOe(tdoOe), .ispArmed(ispArmed), .nvBusy(nvBusy), .cmdStall(cmdStall));

   jisp_jtag_master u_master (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdoLine(tdoLine));

   initial clk = 1'b0;
   always #2.5 clk = ~clk;

   // ********
   // Checking
   // ********
   task automatic fail(input string msg);
      errors++;
      $display("ERROR %0t: %s", $time, msg);
   endtask

   task automatic check1(input logic got, input logic exp, input string msg);
      n_tests++;
      if (got !== exp) fail(msg);
   endtask

   task automatic checkN(input logic [63:0] got, input logic [63:0] exp, input string msg);
      n_tests++;
      if (got !== exp) fail($sformatf("%s got %h exp %h", msg, got, exp));
   endtask

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == TIMEOUT) begin
         fail("timeout");
         print_verdict();
      end
   end

   // Busy width counted off the sampling edge
   always @(negedge clk) begin
      if (nvBusy === 1'b1) busyCnt++;
      // tdo moves only in low phase
      if (reset_n === 1'b1 && tck && tdo !== tdoPrev) fail("tdo moved, tck high");
      tdoPrev = tdo;
   end

   // ********
   // Scenarios
   // ********
   task automatic t_reset();
      check1(tdoOe, 1'b0, "oe at reset");
      check1(ispArmed, 1'b0, "armed at reset");
      u_master.goIdle(1);
      u_master.scan(1'b0, ID_W, 64'h0, rd);
      checkN(rd, 64'(ID_VALUE), "id after reset");
      check1(tdoOe, 1'b0, "oe in idle");
   endtask

   task automatic t_bypass();
      logic [3:0] codes [3];
      codes = '{4'hF, 4'h5, 4'hD};
      for (int i = 0; i < 3; i++) begin
         u_master.scan(1'b1, IR_W, 64'(codes[i]), rd);
         checkN(rd, 64'h1, "ir capture");
         u_master.scan(1'b0, 8, 64'hB4, rd);
         checkN(rd, 64'h68, "bypass path");
         check1(nvBusy, 1'b0, "busy in bypass");
         check1(ispArmed, 1'b0, "armed in bypass");
      end
   endtask

   task automatic t_idcode();
      u_master.scan(1'b1, IR_W, 64'(IR_IDCODE), rd);
      u_master.scan(1'b0, ID_W, 64'h0, rd);
      checkN(rd, 64'(ID_VALUE), "id readout");
   endtask

   task automatic readRow(input logic [5:0] a, output logic [63:0] r);
      u_master.scan(1'b0, PSR_W, 64'({a, 32'h0}), r);
      busyCnt = 0;
      u_master.scan(1'b1, IR_W, 64'(IR_VERIFY), r);
      u_master.goIdle(128);
      checkN(64'(busyCnt), 64'(VERIFY_CYCLES), "verify width");
      u_master.scan(1'b0, PSR_W, 64'h0, r);
   endtask

   task automatic t_program_verify();
      u_master.scan(1'b1, IR_W, 64'(IR_ENABLE), rd);
      check1(ispArmed, 1'b1, "arming");
      u_master.scan(1'b0, PSR_W, 64'({6'h3F, 32'hA5A5_1234}), rd);
      busyCnt = 0;
      u_master.scan(1'b1, IR_W, 64'(IR_PROGRAM), rd);
      u_master.goIdle(2);
      checkN(64'(busyCnt), 64'(PROG_T), "program width");
      check1(cmdStall, 1'b0, "stall");
      readRow(6'h3F, rd);
      checkN(rd, 64'({6'h3F, 32'hA5A5_1234}), "row readback");
   endtask

   task automatic t_erase_disarm();
      busyCnt = 0;
      u_master.scan(1'b1, IR_W, 64'(IR_ERASE), rd);
      u_master.goIdle(6);
      checkN(64'(busyCnt), 64'(ERASE_T), "erase width");
      readRow(6'h3F, rd);
      checkN(rd, 64'({6'h3F, ERASED_ROW}), "erased row");
      u_master.resetTap();
      check1(ispArmed, 1'b0, "disarm at reset state");
      u_master.goIdle(1);
      busyCnt = 0;
      u_master.scan(1'b1, IR_W, 64'(IR_ERASE), rd);
      u_master.goIdle(6);
      checkN(64'(busyCnt), 64'h0, "unarmed erase");
   endtask

   // Power-up reset in mid-session must drop arming and restore the ID path
   task automatic t_midreset();
      u_master.scan(1'b1, IR_W, 64'(IR_ENABLE), rd);
      u_master.scan(1'b1, IR_W, 64'(IR_BYPASS), rd);
      check1(ispArmed, 1'b1, "armed before reset");
      reset_n <= 1'b0;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      check1(ispArmed, 1'b0, "armed after reset");
      check1(tdoOe, 1'b0, "oe after reset");
      u_master.goIdle(1);
      u_master.scan(1'b0, ID_W, 64'h0, rd);
      checkN(rd, 64'(ID_VALUE), "id after mid-run reset");
   endtask

   initial begin
      reset_n = 1'b0;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_reset();
      t_bypass();
      t_idcode();
      t_program_verify();
      t_erase_disarm();
      t_midreset();
      print_verdict();
   end
endmodule // tb_jtag_isp_command_port
